/* File: core/sps_pkg.sv */
/*
  Constants of the status and holding block: offsets, bits, modes, widths.
  Assumes a 32-bit APB bus with byte addresses.
*/
package sps_pkg;
  // Register byte offsets
  localparam logic [7:0] SPS_OFS_CMD = 8'h00; // Command strobes, write only
  localparam logic [7:0] SPS_OFS_CFG = 8'h04; // Mode and enables, read/write
  localparam logic [7:0] SPS_OFS_STATUS = 8'h14; // channel_status, read only
  localparam logic [7:0] SPS_OFS_RX_HOLD = 8'h18; // receive_holding, read only
  localparam logic [7:0] SPS_OFS_TX_HOLD = 8'h1c; // transmit_holding, write only
  localparam logic [7:0] SPS_OFS_IDLE_TO = 8'h24; // Receiver idle timeout value
  localparam int SPS_ADDR_W = 8; // Decoded address width
  // Command register bits
  localparam int SPS_CMD_CLR_STATUS = 8; // clear_status_cmd
  localparam int SPS_CMD_BEGIN_BREAK = 9; // begin_break_cmd
  localparam int SPS_CMD_ARM_IDLE = 11; // arm_rx_idle_cmd
  localparam int SPS_CMD_CLR_NOT_ACK = 14; // clear_not_ack_cmd
  // Config register fields
  localparam int SPS_CFG_MODE_LSB = 0; // Mode field, 4 bits
  localparam int SPS_CFG_RX_EN = 4; // Receiver enable
  localparam int SPS_CFG_TX_EN = 5; // Transmitter enable
  localparam int SPS_MODE_W = 4;
  localparam logic [31:0] SPS_CFG_RESET = 32'h0000_0000;
  // Mode codes
  localparam logic [3:0] SPS_MODE_LIN_MASTER = 4'ha;
  localparam logic [3:0] SPS_MODE_LIN_SLAVE = 4'hb;
  localparam logic [3:0] SPS_MODE_SPI_SLAVE = 4'hf;
  // Status bit positions
  localparam int SPS_ST_LIN_BIT_ERR = 25; // Lowest of the LIN error flags
  localparam int SPS_ST_LIN_BAD_SYNC = 26;
  localparam int SPS_ST_MANCHESTER = 24;
  localparam int SPS_ST_CTS_LIN = 23;
  localparam int SPS_ST_CARRIER = 22;
  localparam int SPS_ST_SET_READY = 21;
  localparam int SPS_ST_RING = 20;
  localparam int SPS_ST_CHANGE_LSB = 16; // Change flags 19..16
  localparam int SPS_ST_LIN_DONE = 15;
  localparam int SPS_ST_LIN_IDENT = 14;
  localparam int SPS_ST_NOT_ACK = 13;
  localparam int SPS_ST_RX_DMA_FULL = 12;
  localparam int SPS_ST_REPEAT_SPI_UNDERRUN_FLAG = 10;
  localparam int SPS_ST_TX_ALL_CLEAR = 9;
  localparam int SPS_ST_RX_IDLE = 8;
  localparam int SPS_ST_PARITY = 7;
  localparam int SPS_ST_FRAME = 6;
  localparam int SPS_ST_OVERRUN = 5;
  localparam int SPS_ST_BREAK = 2;
  localparam int SPS_ST_TX_FREE = 1;
  localparam int SPS_ST_RX_WAITING = 0;
  // Holding register fields
  localparam int SPS_CHAR_W = 9; // Character bits 8..0
  localparam int SPS_HOLD_TAG = 15; // Command tag bit
  localparam int SPS_LIN_ERR_N = 6; // Flags at 31..27 and 25
  localparam int SPS_MODEM_N = 4; // CTS, DCD, DSR, RI
  localparam int SPS_IDLE_TO_W = 17;
  localparam logic [31:0] SPS_WORD_ZERO = 32'h0000_0000;
endpackage : sps_pkg

/* File: core/sps_status_holding.sv */
/*
  Status and holding registers of a multi-mode serial port, APB slave.
  Assumes shifters on core_clk pulse events for one cycle; modem and
  LIN line inputs are asynchronous.
*/
//
// Contract
// - LIN error flags sticky until status clear
// - Bad sync flag only as LIN slave
// - Manchester error sticky until status clear
// - Bit 23 shows CTS, or LIN line
// - Bits 22..20 mirror DCD, DSR, RI live
// - Modem change flags, cleared by status read
// - LIN transfer done flag, sticky
// - LIN identifier sent or received flag
// - Not-ack flag cleared only by own command
// - Bit 12 follows receive DMA full
// - Bit 10 underrun in SPI slave, else repeat
// - Transmitter fully empty and enabled flag
// - Idle timeout flag, zero when value zero
// - Parity, framing, overrun flags sticky
// - Break start or end flag, sticky
// - Holding free flag, enabled and no break
// - Receive ready flag, re-enable resume
// - Receive holding: character and command tag
// - Written character queued behind current one
`timescale 1ns/1ps
module sps_status_holding
  import sps_pkg::*;
(
  input wire logic core_clk,
  input wire logic sys_rst,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Asynchronous line inputs
  input wire logic cts_pin,
  input wire logic carrier_pin,
  input wire logic set_ready_pin,
  input wire logic ring_pin,
  input wire logic lin_line_pin,
  // Same-clock event pulses from the shifters, and the receive DMA full level
  input wire logic [sps_pkg::SPS_LIN_ERR_N-1:0] lin_err_evt,
  input wire logic lin_bad_sync_evt,
  input wire logic manchester_err_evt,
  input wire logic lin_done_evt,
  input wire logic lin_ident_evt,
  input wire logic not_ack_evt,
  input wire logic repeat_limit_evt,
  input wire logic spi_underrun_evt,
  input wire logic rx_idle_expired_evt,
  input wire logic parity_err_evt,
  input wire logic frame_err_evt,
  input wire logic overrun_evt,
  input wire logic break_evt,
  input wire logic rx_dma_full,
  // Receive shifter side
  input wire logic rx_char_valid,
  input wire logic [sps_pkg::SPS_CHAR_W-1:0] rx_char_data,
  input wire logic rx_char_cmd,
  input wire logic rx_busy,
  // Transmit shifter side
  input wire logic tx_shift_empty,
  input wire logic tx_take,
  input wire logic break_started,
  output logic tx_hold_valid,
  output logic [sps_pkg::SPS_CHAR_W-1:0] tx_hold_char,
  output logic tx_hold_cmd,
  output logic break_pending,
  // Configuration seen by the shifters
  output logic [sps_pkg::SPS_MODE_W-1:0] port_mode,
  output logic rx_enable,
  output logic tx_enable,
  output logic [sps_pkg::SPS_IDLE_TO_W-1:0] rx_idle_value,
  output logic rx_idle_arm
);
  import sps_pkg::*;

  // Bus decode
  logic [SPS_ADDR_W-1:0] addr; // Low address bits
  logic addr_hi_zero; // Upper address bits clear
  logic setup_rd; // Read setup cycle
  logic acc; // Access cycle
  logic wr_acc; // Completing write
  logic rd_acc; // Completing read
  logic hit_cmd, hit_cfg, hit_status, hit_rx, hit_tx, hit_to; // Register hits
  logic mapped; // Register of the right direction

  // Control state
  logic [31:0] cfg_q; // Mode and enables
  logic [SPS_IDLE_TO_W-1:0] idle_to_q; // Idle timeout value
  logic [31:0] prdata_q; // Read data, loaded in setup
  logic clr_status; // Status clear strobe
  logic clr_not_ack; // Not-ack clear strobe
  logic arm_idle; // Idle timeout arm strobe
  logic begin_brk; // Break request strobe
  logic lin_mode; // Either LIN mode

  // Sticky flags
  logic [SPS_LIN_ERR_N-1:0] lin_err_q; // LIN error flags
  logic lin_bad_sync_q, manchester_q, lin_done_q, lin_ident_q;
  logic not_ack_q, repeat_spi_underrun_flag_q, rx_idle_q;
  logic parity_q, frame_q, overrun_q, break_q;
  logic rx_waiting_q; // Character in receive holding
  logic rx_resume_q; // Disabled mid-character, report on re-enable
  logic rx_en_prev_q; // Receiver enable of last cycle

  // Modem lines
  logic [SPS_MODEM_N-1:0] modem_raw; // CTS, DCD, DSR, RI at the pins
  logic [SPS_MODEM_N-1:0] modem_s1_q; // First synchroniser stage
  logic [SPS_MODEM_N-1:0] modem_s2_q; // Safe level
  logic [SPS_MODEM_N-1:0] modem_prev_q; // Level of previous cycle
  logic [SPS_MODEM_N-1:0] modem_change_q; // Change flags
  logic lin_s1_q, lin_s2_q; // LIN line synchroniser

  // Receive and transmit holding
  logic [SPS_CHAR_W-1:0] rx_char_q; // Last received character
  logic rx_tag_q; // Last received tag
  logic tx_valid_q; // Transmit holding full
  logic [SPS_CHAR_W-1:0] tx_char_q; // Queued character
  logic tx_tag_q; // Queued tag
  logic break_pend_q; // Break request outstanding

  // Status image
  logic [31:0] status_word; // Assembled channel status
  logic tx_free; // Holding free flag value
  logic tx_all_clear; // Transmitter empty flag value

  assign addr = paddr[SPS_ADDR_W-1:0];
  assign addr_hi_zero = (paddr[31:SPS_ADDR_W] == '0);
  assign acc = psel & penable;
  assign setup_rd = psel & ~penable & ~pwrite;
  assign hit_cmd = addr_hi_zero & (addr == SPS_OFS_CMD);
  assign hit_cfg = addr_hi_zero & (addr == SPS_OFS_CFG);
  assign hit_status = addr_hi_zero & (addr == SPS_OFS_STATUS);
  assign hit_rx = addr_hi_zero & (addr == SPS_OFS_RX_HOLD);
  assign hit_tx = addr_hi_zero & (addr == SPS_OFS_TX_HOLD);
  assign hit_to = addr_hi_zero & (addr == SPS_OFS_IDLE_TO);
  // Read-only and write-only registers refuse the wrong direction
  assign mapped = pwrite ? (hit_cmd | hit_cfg | hit_tx | hit_to)
                         : (hit_cfg | hit_status | hit_rx | hit_to);
  assign wr_acc = acc & pwrite & mapped;
  assign rd_acc = acc & ~pwrite & mapped;

  // Zero wait states; error answer on unmapped access
  assign pready = 1'b1;
  assign pslverr = acc & ~mapped;
  assign prdata = prdata_q;

  // Command strobes act at the completing write edge
  assign clr_status = wr_acc & hit_cmd & pwdata[SPS_CMD_CLR_STATUS];
  assign clr_not_ack = wr_acc & hit_cmd & pwdata[SPS_CMD_CLR_NOT_ACK];
  assign arm_idle = wr_acc & hit_cmd & pwdata[SPS_CMD_ARM_IDLE];
  assign begin_brk = wr_acc & hit_cmd & pwdata[SPS_CMD_BEGIN_BREAK];

  assign port_mode = cfg_q[SPS_CFG_MODE_LSB +: SPS_MODE_W];
  assign rx_enable = cfg_q[SPS_CFG_RX_EN];
  assign tx_enable = cfg_q[SPS_CFG_TX_EN];
  assign rx_idle_value = idle_to_q;
  assign rx_idle_arm = arm_idle;
  assign lin_mode = (port_mode == SPS_MODE_LIN_MASTER) | (port_mode == SPS_MODE_LIN_SLAVE);

  // Configuration and timeout registers
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      cfg_q <= SPS_CFG_RESET;
      idle_to_q <= '0;
    end else begin
      if (wr_acc && hit_cfg) begin
        cfg_q <= pwdata;
      end
      if (wr_acc && hit_to) begin
        idle_to_q <= pwdata[SPS_IDLE_TO_W-1:0];
      end
    end
  end

  // Read data is captured in the setup cycle so it comes from a flop
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      prdata_q <= SPS_WORD_ZERO;
    end else if (setup_rd) begin
      if (hit_status) begin
        prdata_q <= status_word;
      end else if (hit_rx) begin
        prdata_q <= SPS_WORD_ZERO;
        prdata_q[SPS_CHAR_W-1:0] <= rx_char_q;
        prdata_q[SPS_HOLD_TAG] <= rx_tag_q;
      end else if (hit_cfg) begin
        prdata_q <= cfg_q;
      end else if (hit_to) begin
        prdata_q <= {{(32-SPS_IDLE_TO_W){1'b0}}, idle_to_q};
      end else begin
        // Unmapped or write-only reads return zero
        prdata_q <= SPS_WORD_ZERO;
      end
    end
  end

  // Two-flop synchronisers for asynchronous pins
  assign modem_raw = {cts_pin, carrier_pin, set_ready_pin, ring_pin};
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      modem_s1_q <= '0;
      modem_s2_q <= '0;
      lin_s1_q <= 1'b0;
      lin_s2_q <= 1'b0;
    end else begin
      modem_s1_q <= modem_raw;
      modem_s2_q <= modem_s1_q;
      lin_s1_q <= lin_line_pin;
      lin_s2_q <= lin_s1_q;
    end
  end

  // Change flags; a read clears only what its snapshot reported, so a
  // change landing at the setup edge is not lost
  genvar gi;
  generate
    for (gi = 0; gi < SPS_MODEM_N; gi++) begin : g_modem
      always_ff @(posedge core_clk) begin
        if (sys_rst) begin
          modem_prev_q[gi] <= 1'b0;
          modem_change_q[gi] <= 1'b0;
        end else begin
          modem_prev_q[gi] <= modem_s2_q[gi];
          if (modem_s2_q[gi] != modem_prev_q[gi]) begin
            modem_change_q[gi] <= 1'b1;
          end else if (rd_acc && hit_status && prdata_q[SPS_ST_CHANGE_LSB + gi]) begin
            modem_change_q[gi] <= 1'b0;
          end
        end
      end
    end
  endgenerate

  // LIN error flags: set wins over the status clear
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      lin_err_q <= '0;
      lin_bad_sync_q <= 1'b0;
      lin_done_q <= 1'b0;
      lin_ident_q <= 1'b0;
    end else begin
      lin_err_q <= (lin_err_q & ~{SPS_LIN_ERR_N{clr_status}}) | lin_err_evt;
      // Inconsistent sync only counts when acting as slave
      lin_bad_sync_q <= (lin_bad_sync_q & ~clr_status)
                      | (lin_bad_sync_evt & (port_mode == SPS_MODE_LIN_SLAVE));
      lin_done_q <= (lin_done_q & ~clr_status) | lin_done_evt;
      // Identifier event: received as slave, sent as master
      lin_ident_q <= (lin_ident_q & ~clr_status) | (lin_ident_evt & lin_mode);
    end
  end

  // Other protocol error and event flags
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      manchester_q <= 1'b0;
      not_ack_q <= 1'b0;
      repeat_spi_underrun_flag_q <= 1'b0;
      parity_q <= 1'b0;
      frame_q <= 1'b0;
      overrun_q <= 1'b0;
      break_q <= 1'b0;
    end else begin
      manchester_q <= (manchester_q & ~clr_status) | manchester_err_evt;
      // Status clear deliberately leaves this flag alone
      not_ack_q <= (not_ack_q & ~clr_not_ack) | not_ack_evt;
      // One bit, two meanings chosen by mode
      repeat_spi_underrun_flag_q <= (repeat_spi_underrun_flag_q & ~clr_status)
                     | ((port_mode == SPS_MODE_SPI_SLAVE) ? spi_underrun_evt
                                                          : repeat_limit_evt);
      parity_q <= (parity_q & ~clr_status) | parity_err_evt;
      frame_q <= (frame_q & ~clr_status) | frame_err_evt;
      overrun_q <= (overrun_q & ~clr_status) | overrun_evt;
      break_q <= (break_q & ~clr_status) | break_evt;
    end
  end

  // Idle timeout flag: restarted by the arm command, blocked by a zero value
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      rx_idle_q <= 1'b0;
    end else if (idle_to_q == '0) begin
      rx_idle_q <= 1'b0;
    end else if (rx_idle_expired_evt) begin
      rx_idle_q <= 1'b1;
    end else if (arm_idle) begin
      rx_idle_q <= 1'b0;
    end
  end

  // Receive holding and ready flag
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      rx_char_q <= '0;
      rx_tag_q <= 1'b0;
      rx_waiting_q <= 1'b0;
      rx_resume_q <= 1'b0;
      rx_en_prev_q <= 1'b0;
    end else begin
      rx_en_prev_q <= rx_enable;
      if (rx_char_valid) begin
        rx_char_q <= rx_char_data;
        rx_tag_q <= rx_char_cmd;
      end
      // Disable mid-character is remembered until re-enable
      if (rx_en_prev_q && !rx_enable && rx_busy) begin
        rx_resume_q <= 1'b1;
      end else if (rx_enable && !rx_en_prev_q) begin
        rx_resume_q <= 1'b0;
      end
      // New character or resumption wins over the holding read
      if (rx_char_valid || (rx_enable && !rx_en_prev_q && rx_resume_q)) begin
        rx_waiting_q <= 1'b1;
      end else if (rd_acc && hit_rx) begin
        rx_waiting_q <= 1'b0;
      end
    end
  end

  // Transmit holding: one character waits behind the shifter
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      tx_valid_q <= 1'b0;
      tx_char_q <= '0;
      tx_tag_q <= 1'b0;
    end else begin
      if (wr_acc && hit_tx) begin
        // A write over a full holding replaces the waiting character
        tx_valid_q <= 1'b1;
        tx_char_q <= pwdata[SPS_CHAR_W-1:0];
        tx_tag_q <= pwdata[SPS_HOLD_TAG];
      end else if (tx_take && tx_valid_q) begin
        tx_valid_q <= 1'b0;
      end
    end
  end

  // Break request waits until the shifter starts it
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      break_pend_q <= 1'b0;
    end else if (begin_brk) begin
      break_pend_q <= 1'b1;
    end else if (break_started) begin
      break_pend_q <= 1'b0;
    end
  end

  assign tx_hold_valid = tx_valid_q;
  assign tx_hold_char = tx_char_q;
  assign tx_hold_cmd = tx_tag_q;
  assign break_pending = break_pend_q;

  // Live flags; a disabled transmitter forces both low
  assign tx_free = tx_enable & ~tx_valid_q & ~break_pend_q;
  assign tx_all_clear = tx_enable & ~tx_valid_q & tx_shift_empty;

  // Channel status image; unused bits read zero
  always_comb begin
    status_word = SPS_WORD_ZERO;
    status_word[31:27] = lin_err_q[SPS_LIN_ERR_N-1:1];
    status_word[SPS_ST_LIN_BIT_ERR] = lin_err_q[0];
    status_word[SPS_ST_LIN_BAD_SYNC] = lin_bad_sync_q;
    status_word[SPS_ST_MANCHESTER] = manchester_q;
    status_word[SPS_ST_CTS_LIN] = lin_mode ? lin_s2_q : modem_s2_q[3];
    status_word[SPS_ST_CARRIER] = modem_s2_q[2];
    status_word[SPS_ST_SET_READY] = modem_s2_q[1];
    status_word[SPS_ST_RING] = modem_s2_q[0];
    status_word[SPS_ST_CHANGE_LSB +: SPS_MODEM_N] = modem_change_q;
    status_word[SPS_ST_LIN_DONE] = lin_done_q;
    status_word[SPS_ST_LIN_IDENT] = lin_ident_q;
    status_word[SPS_ST_NOT_ACK] = not_ack_q;
    status_word[SPS_ST_RX_DMA_FULL] = rx_dma_full;
    status_word[SPS_ST_REPEAT_SPI_UNDERRUN_FLAG] = repeat_spi_underrun_flag_q;
    status_word[SPS_ST_TX_ALL_CLEAR] = tx_all_clear;
    status_word[SPS_ST_RX_IDLE] = rx_idle_q;
    status_word[SPS_ST_PARITY] = parity_q;
    status_word[SPS_ST_FRAME] = frame_q;
    status_word[SPS_ST_OVERRUN] = overrun_q;
    status_word[SPS_ST_BREAK] = break_q;
    status_word[SPS_ST_TX_FREE] = tx_free;
    // Ready reads low while the receiver is off
    status_word[SPS_ST_RX_WAITING] = rx_waiting_q & rx_enable;
  end
endmodule : sps_status_holding

/* File: dv/sps_chk.sv */
/*
  Port checker of the status block.
  Assumes the bind below reaches every instance.
*/
`timescale 1ns/1ps
module sps_chk
  import sps_pkg::*;
(
  input wire logic core_clk,
  input wire logic sys_rst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic rx_dma_full,
  input wire logic parity_err_evt,
  input wire logic frame_err_evt,
  input wire logic overrun_evt,
  input wire logic break_evt,
  input wire logic not_ack_evt,
  input wire logic tx_take,
  input wire logic tx_hold_valid,
  input wire logic [sps_pkg::SPS_CHAR_W-1:0] tx_hold_char,
  input wire logic tx_hold_cmd,
  input wire logic break_pending
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (sys_rst);
  wire acc = psel && penable; // Completing cycle of a transfer
  wire wr = acc && pwrite;
  // No error event, so set-wins cannot mask a clear
  wire quiet = !(parity_err_evt || frame_err_evt || overrun_evt || break_evt);
  logic [31:0] wd_q; // Write data of the previous cycle
  always_ff @(posedge core_clk) begin
    wd_q <= pwdata;
  end
  // Setup cycle of a status read
  sequence s_rd_st;
    quiet && psel && !penable && !pwrite && paddr == {24'h0, SPS_OFS_STATUS};
  endsequence
  // Completing write of the status clear without the not-ack clear
  sequence s_clr;
    quiet && wr && paddr == {24'h0, SPS_OFS_CMD} && pwdata[SPS_CMD_CLR_STATUS]
      && !pwdata[SPS_CMD_CLR_NOT_ACK];
  endsequence
  a_unmapped_err: assert property (acc && paddr == 32'h8 |-> pslverr)
    else $error("unmapped access not refused");
  a_status_ok: assert property (acc && !pwrite && paddr == 32'h14 |-> pready && !pslverr)
    else $error("status read refused");
  a_dma_live: assert property (s_rd_st |=> prdata[12] == $past(rx_dma_full))
    else $error("dma full bit wrong");
  a_parity_hold: assert property (parity_err_evt ##1 s_rd_st |=> prdata[7])
    else $error("parity flag lost");
  a_clear_wipe: assert property (s_clr ##1 s_rd_st |=> prdata[7:5] == 3'h0 && !prdata[2])
    else $error("flags survive clear");
  a_not_ack_flag_keep: assert property (not_ack_evt ##2 s_clr ##1 s_rd_st |=> prdata[13])
    else $error("not-ack lost on status clear");
  a_hold_load: assert property (wr && paddr == 32'h1c && !tx_take |=> tx_hold_valid
    && tx_hold_char == wd_q[8:0] && tx_hold_cmd == wd_q[15])
    else $error("holding register not loaded");
  a_take_frees: assert property (tx_take && !(wr && paddr == 32'h1c) |=> !tx_hold_valid)
    else $error("holding still full after take");
  a_break_req: assert property (wr && paddr == 32'h0 && pwdata[9] |=> break_pending)
    else $error("break request not pending");
endmodule // sps_chk

bind sps_status_holding sps_chk chk_u (.*);

/* File: dv/sps_far_node.sv */
/*
  Far-side shifter model: takes held characters, starts breaks.
  Assumes one-cycle take and break pulses.
*/
`timescale 1ns/1ps
module sps_far_node
  import sps_pkg::*;
#(
  parameter int DLY = 3, // Cycles a character waits before the take
  parameter int BITS = 8 // Busy cycles per character or break
) (
  input wire logic core_clk,
  input wire logic sys_rst,
  input wire logic tx_hold_valid,
  input wire logic [sps_pkg::SPS_CHAR_W-1:0] tx_hold_char,
  input wire logic tx_hold_cmd,
  input wire logic break_pending,
  output logic tx_take,
  output logic tx_shift_empty,
  output logic break_started,
  output logic got_vld,
  output logic [sps_pkg::SPS_CHAR_W:0] got_word
);
  int wait_q; // Delay count before a take
  int busy_q; // Remaining busy cycles of the line
  assign tx_shift_empty = (busy_q == 0);
  // Busy guards against a second take before the block drops its valid
  always_ff @(posedge core_clk) begin
    tx_take <= 1'b0;
    break_started <= 1'b0;
    got_vld <= 1'b0;
    if (sys_rst) begin
      wait_q <= 0;
      busy_q <= 0;
    end else if (busy_q != 0) begin
      busy_q <= busy_q - 1;
    end else if (break_pending) begin
      break_started <= 1'b1;
      busy_q <= BITS;
    end else if (tx_hold_valid && wait_q == DLY) begin
      tx_take <= 1'b1;
      got_vld <= 1'b1;
      got_word <= {tx_hold_cmd, tx_hold_char};
      busy_q <= BITS;
      wait_q <= 0;
    end else if (tx_hold_valid) begin
      wait_q <= wait_q + 1;
    end
  end
endmodule // sps_far_node

/* File: dv/tb_top.sv */
/*
  Bench: APB driver, event pulses, far-side model, queue monitor.
  Assumes one 25 MHz clock.
*/
`timescale 1ns/1ps
module tb_top;
  import sps_pkg::*;
  typedef struct {logic [31:0] d; logic [31:0] m; logic e;} sps_note_t;
  localparam logic [31:0] STK = 32'hff00_c4e4; // Flags wiped by status clear
  logic core_clk = 1'b0;
  logic sys_rst = 1'b1;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [31:0] paddr = '0;
  logic [31:0] pwdata = '0;
  logic [4:0] pins = '0; // CTS, carrier, set ready, ring, LIN line
  logic [17:0] ev = '0; // Event pulses, mapped at the instance
  logic rx_dma_full = 1'b0;
  logic rx_char_valid = 1'b0;
  logic rx_char_cmd = 1'b0;
  logic rx_busy = 1'b0;
  logic [8:0] rx_char_data = '0;
  logic [31:0] prdata;
  logic pready, pslverr, tx_take, tx_shift_empty, break_started;
  logic tx_hold_valid, tx_hold_cmd, break_pending, got_vld;
  logic [8:0] tx_hold_char;
  logic [9:0] got_word;
  int n_errors = 0;
  int n_checks = 0;
  sps_note_t q[$]; // Expected APB answers, oldest first
  logic [9:0] txq[$]; // Expected characters on the line
  logic [31:0] rnd = 32'h6141_210c;
  int stb[15] = '{25, 27, 28, 29, 30, 31, 26, 24, 15, 14, 10, 7, 6, 5, 2};
  int i;

  sps_status_holding dut_u (
    .core_clk, .sys_rst, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
    .pslverr, .cts_pin(pins[4]), .carrier_pin(pins[3]), .set_ready_pin(pins[2]),
    .ring_pin(pins[1]), .lin_line_pin(pins[0]), .lin_err_evt(ev[5:0]),
    .lin_bad_sync_evt(ev[6]), .manchester_err_evt(ev[7]), .lin_done_evt(ev[8]),
    .lin_ident_evt(ev[9]), .repeat_limit_evt(ev[10]), .parity_err_evt(ev[11]),
    .frame_err_evt(ev[12]), .overrun_evt(ev[13]), .break_evt(ev[14]), .not_ack_evt(ev[15]),
    .spi_underrun_evt(ev[16]), .rx_idle_expired_evt(ev[17]), .rx_dma_full,
    .rx_char_valid, .rx_char_data, .rx_char_cmd, .rx_busy, .tx_shift_empty, .tx_take,
    .break_started, .tx_hold_valid, .tx_hold_char, .tx_hold_cmd, .break_pending,
    .port_mode(), .rx_enable(), .tx_enable(), .rx_idle_value(), .rx_idle_arm());

  sps_far_node #(.DLY(3), .BITS(8)) far_u (
    .core_clk, .sys_rst, .tx_hold_valid, .tx_hold_char, .tx_hold_cmd, .break_pending,
    .tx_take, .tx_shift_empty, .break_started, .got_vld, .got_word);

  always #20 core_clk = ~core_clk;

  function automatic logic [31:0] nx(logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction

  task automatic fail(string s);
    $display("[ERR] %0t %s", $time, s);
    n_errors++;
  endtask

  task automatic stop_test();
    $display("checks %0d errors %0d", n_checks, n_errors);
    if (n_errors == 0 && n_checks > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask

  // One transfer; last releases the bus
  task automatic ap(logic w, logic [31:0] a, d, ex, m, logic e, logic last);
    int n;
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    q.push_back('{ex, m, e});
    @(posedge core_clk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge core_clk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (n >= 20) begin
      fail("no ready");
      stop_test();
    end
    if (last) begin
      psel <= 1'b0;
      penable <= 1'b0;
    end
  endtask

  task automatic wr(logic [31:0] a, d, logic last = 1'b1);
    ap(1'b1, a, d, '0, '0, 1'b0, last);
  endtask

  task automatic rd(logic [31:0] a, ex, m, logic last = 1'b1);
    ap(1'b0, a, '0, ex, m, 1'b0, last);
  endtask

  task automatic st(logic [31:0] ex, m, logic last = 1'b1);
    rd(32'h14, ex, m, last);
  endtask

  task automatic pulse(logic [17:0] v);
    ev <= v;
    @(posedge core_clk);
    ev <= '0;
  endtask

  // Random character, noted for the line monitor
  task automatic tw(logic last);
    rnd = nx(rnd);
    txq.push_back({rnd[15], rnd[8:0]});
    wr(32'h1c, rnd & 32'h0000_81ff, last);
  endtask

  // Wait for holding (and with full, shifter) to drain
  task automatic wt(logic full);
    int n;
    n = 0;
    do begin
      @(negedge core_clk);
      n++;
    end while ((tx_hold_valid || (full && !tx_shift_empty)) && n < 100);
    if (n >= 100) begin
      fail("transmit stuck");
      stop_test();
    end
    @(posedge core_clk);
  endtask

  // Monitor: settled values mid-cycle, oldest note first
  always @(negedge core_clk) begin
    sps_note_t nt;
    if (psel && penable && pready) begin
      n_checks++;
      if (q.size() == 0) fail("unexpected transfer");
      else begin
        nt = q.pop_front();
        if ((prdata & nt.m) !== (nt.d & nt.m) || pslverr !== nt.e)
          fail($sformatf("addr %h got %h want %h", paddr, prdata, nt.d));
      end
    end
    if (got_vld) begin
      n_checks++;
      if (txq.size() == 0 || got_word !== txq.pop_front()) fail("wrong character sent");
    end
  end

  initial begin
    repeat (4) @(posedge core_clk);
    sys_rst <= 1'b0;
    st(32'h0, 32'hffff_ffff);
    rd(32'h18, 32'h0, 32'hffff_ffff);
    ap(1'b0, 32'h8, '0, '0, 32'hffff_ffff, 1'b1, 1'b0);
    ap(1'b1, 32'h14, 32'hffff_ffff, '0, '0, 1'b1, 1'b0);
    wr(32'h4, 32'h3b);
    pulse(18'h1 << 17);
    st(32'h0, 32'h100);
    for (i = 0; i < 15; i++) begin
      pulse(18'h1 << i);
      st(32'h1 << stb[i], STK, 1'b0);
      wr(32'h0, 32'h100, 1'b0);
      st(32'h0, STK);
    end
    pulse(18'h1 << 15);
    wr(32'h0, 32'h100, 1'b0);
    st(32'h2000, 32'h2000, 1'b0);
    wr(32'h0, 32'h4000, 1'b0);
    st(32'h0, 32'h2000);
    pulse(18'h1 << 16);
    st(32'h0, 32'h400, 1'b0);
    wr(32'h4, 32'h3f);
    pulse(18'h1 << 16);
    st(32'h400, 32'h400, 1'b0);
    wr(32'h0, 32'h100);
    pulse(18'h1 << 10);
    st(32'h0, 32'h400, 1'b0);
    wr(32'h4, 32'h3a);
    pulse(18'h1 << 6);
    st(32'h0, 32'h0400_0000, 1'b0);
    wr(32'h24, 32'h5);
    pulse(18'h1 << 17);
    st(32'h100, 32'h100, 1'b0);
    wr(32'h0, 32'h800, 1'b0);
    st(32'h0, 32'h100, 1'b0);
    rd(32'h24, 32'h5, 32'h1_ffff, 1'b0);
    wr(32'h4, 32'h30);
    pins <= 5'b10110;
    repeat (6) @(posedge core_clk);
    st(32'h00bb_0000, 32'h00ff_0000, 1'b0);
    st(32'h00b0_0000, 32'h00ff_0000, 1'b0);
    wr(32'h4, 32'h3a, 1'b0);
    st(32'h0, 32'h0080_0000, 1'b0);
    wr(32'h4, 32'h30);
    rx_dma_full <= 1'b1;
    st(32'h1000, 32'h1000);
    rx_dma_full <= 1'b0;
    st(32'h0, 32'h1000);
    for (i = 0; i < 2; i++) begin
      rnd = nx(rnd);
      rx_char_data <= rnd[8:0];
      rx_char_cmd <= rnd[9];
      rx_char_valid <= 1'b1;
      @(posedge core_clk);
      rx_char_valid <= 1'b0;
      st(32'h1, 32'h1, 1'b0);
      rd(32'h18, {16'h0, rnd[9], 6'h0, rnd[8:0]}, 32'h81ff, 1'b0);
      st(32'h0, 32'h1);
    end
    rx_busy <= 1'b1;
    wr(32'h4, 32'h20, 1'b0);
    st(32'h0, 32'h1);
    rx_busy <= 1'b0;
    wr(32'h4, 32'h30);
    @(posedge core_clk);
    st(32'h1, 32'h1, 1'b0);
    rd(32'h18, '0, '0);
    tw(1'b1);
    wt(1'b0);
    tw(1'b0);
    st(32'h0, 32'h202);
    wt(1'b1);
    st(32'h202, 32'h202, 1'b0);
    wr(32'h0, 32'h200, 1'b0);
    st(32'h0, 32'h2);
    wt(1'b1);
    wr(32'h4, 32'h0, 1'b0);
    st(32'h0, 32'h202);
    repeat (20) @(posedge core_clk);
    if (q.size() != 0 || txq.size() != 0) fail("answers left over");
    stop_test();
  end
endmodule // tb_top
